// ### common/port_test_pkg.sv
// Package: register map, field layout and types for the port test-mode block
`default_nettype none
package port_test_pkg;
  localparam logic [7:0] port_test_control_off       = 8'h50;
  localparam logic [7:0] test_dma_setup_off          = 8'h70;
  localparam logic [7:0] test_dma_memory_address_off = 8'h74;
  localparam logic [7:0] test_dma_status_off         = 8'h78;
  localparam int force_j_bit            = 0;
  localparam int force_k_bit            = 1;
  localparam int packet_pattern_bit     = 2;
  localparam int loopback_bit           = 4;
  localparam int dma_start_bit          = 0;
  localparam int dma_dir_bit            = 1;
  localparam int len_lsb                = 8;
  localparam int len_msb                = 24;
  localparam int len_w                  = 17;
  localparam int done_flag_bit          = 0;
  localparam int done_irq_en_bit        = 1;
  localparam int busy_bit               = 2;
  localparam logic [31:0] ctrl_wmask    = 32'h0000_0017;
  localparam logic [31:0] setup_wmask   = 32'h01ff_ff03;
  localparam logic [len_w-1:0] len_max  = 17'h003ff;
  localparam int wait_ns                = 150;
  localparam int clk_period_ns          = 8;
  localparam int wait_cycles            = (wait_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [4:0] wait_cycles_c  = 5'(wait_cycles);
  localparam logic [4:0] zero5          = 5'h00;
  localparam logic [31:0] zero32        = 32'h0000_0000;

  typedef enum logic [1:0] {line_idle, line_j, line_k, line_loop} line_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0]  data;
    logic        we;
    logic        req;
  } mem_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } byte_beat_t;
endpackage
`default_nettype wire

// ### rtl/port_line_driver.sv
// Port line driver: forced J/K levels, loopback and test-packet byte stream
`default_nettype none
module port_line_driver
  import port_test_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [31:0] ctrl,
  input  wire byte_beat_t  fifo_byte,
  output logic             fifo_ready,
  output line_state_t      line_reg,
  output byte_beat_t       tx_reg
);
  line_state_t line_next;
  byte_beat_t  tx_next;

  always_comb
  begin
    line_next = line_idle;
    if (ctrl[loopback_bit])
      line_next = line_loop;
    else if (ctrl[force_k_bit])
      line_next = line_k;
    else if (ctrl[force_j_bit])
      line_next = line_j;
    tx_next = '0;
    if (ctrl[packet_pattern_bit] && fifo_byte.valid)
      tx_next = fifo_byte;
  end

  // Transceiver always accepts in packet mode; elsewhere the FIFO holds bytes
  assign fifo_ready = ctrl[packet_pattern_bit];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_reg <= line_idle;
      tx_reg   <= '0;
    end
    else if (ce)
    begin
      line_reg <= line_next;
      tx_reg   <= tx_next;
    end
  end
endmodule
`default_nettype wire

// ### rtl/test_dma_engine.sv
// Byte DMA between local memory and the transmit or receive FIFO for test packets
`default_nettype none
module test_dma_engine
  import port_test_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             ce,
  input  wire logic             start,
  input  wire logic             to_fifo,
  input  wire logic [len_w-1:0] len,
  input  wire logic [31:0]      base,
  input  wire logic [7:0]       mem_rdata,
  input  wire logic             fifo_ready,
  input  wire byte_beat_t       fifo_in,
  output mem_req_t              mem_reg,
  output byte_beat_t            fifo_out,
  output logic                  busy_reg,
  output logic                  done_pulse
);
  logic [len_w-1:0] left_reg, left_next;
  logic [31:0]      ptr_reg, ptr_next;
  logic             busy_next, pend_reg, pend_next, dir_reg, dir_next;
  mem_req_t         mem_next;

  // Memory answers the cycle after it sees req; pend marks a byte in flight
  // Direction is latched at start so later bus traffic cannot flip it
  always_comb
  begin
    left_next  = left_reg;
    busy_next  = busy_reg;
    pend_next  = 1'b0;
    mem_next   = mem_reg;
    mem_next.req = 1'b0;
    mem_next.we  = 1'b0;
    ptr_next   = ptr_reg;
    dir_next   = dir_reg;
    done_pulse = 1'b0;
    fifo_out   = '0;
    if (!busy_reg)
    begin
      if (start)
      begin
        busy_next = (len != '0);
        done_pulse = (len == '0);
        left_next = (len > len_max) ? len_max : len;
        dir_next = to_fifo;
        ptr_next = base;
      end
    end
    else if (dir_reg)
    begin
      // First cycle after req the memory has not answered yet
      if (pend_reg && mem_reg.req)
        pend_next = 1'b1;
      else if (pend_reg)
      begin
        fifo_out.valid = 1'b1;
        fifo_out.data  = mem_rdata;
        if (fifo_ready)
        begin
          left_next = left_reg - 1'b1;
          ptr_next = ptr_reg + 32'h1;
          if (left_reg == 17'h1)
          begin
            busy_next = 1'b0;
            done_pulse = 1'b1;
          end
        end
        // Refused byte is fetched again: the read lines do not hold it
      end
      else
      begin
        mem_next.req = 1'b1;
        pend_next = 1'b1;
      end
    end
    else if (fifo_in.valid)
    begin
      mem_next.req  = 1'b1;
      mem_next.we   = 1'b1;
      mem_next.data = fifo_in.data;
      ptr_next = ptr_reg + 32'h1;
      left_next = left_reg - 1'b1;
      if (left_reg == 17'h1)
      begin
        busy_next = 1'b0;
        done_pulse = 1'b1;
      end
    end
    mem_next.addr = ptr_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      left_reg <= '0;
      busy_reg <= 1'b0;
      pend_reg <= 1'b0;
      ptr_reg  <= '0;
      dir_reg  <= 1'b0;
      mem_reg  <= '0;
    end
    else if (ce)
    begin
      left_reg <= left_next;
      busy_reg <= busy_next;
      pend_reg <= pend_next;
      ptr_reg  <= ptr_next;
      dir_reg  <= dir_next;
      mem_reg  <= mem_next;
    end
  end
endmodule
`default_nettype wire

// ### rtl/port_test_mode_control.sv
// Top: APB register file for port test mode and test-packet DMA
//
// The implementer's own choice: the APB register port.
`default_nettype none
module port_test_mode_control
  import port_test_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  mem_rdata,
  input  wire byte_beat_t  rx_byte,
  output mem_req_t         mem_req,
  output line_state_t      line_state,
  output byte_beat_t       tx_byte,
  output logic             irq
);
  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] setup_reg, setup_next;
  logic [31:0] addr_reg, addr_next;
  logic        done_reg, done_next;
  logic        irq_en_reg, irq_en_next;
  logic        irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next, pslverr_reg, pslverr_next;
  logic [4:0]  gap_reg, gap_next;
  logic        dma_busy, dma_done, fifo_ready, start_pulse;
  byte_beat_t  fifo_byte;
  mem_req_t    mem_q;
  line_state_t line_q;
  byte_beat_t  tx_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  wire access = psel && penable && !pready_reg;
  wire wr     = access && pwrite;

  // Start only honoured in packet mode so the DMA stays inert otherwise
  assign start_pulse = wr && hit(paddr, test_dma_setup_off)
                       && pwdata[dma_start_bit] && ctrl_reg[packet_pattern_bit];

  always_comb
  begin
    ctrl_next    = ctrl_reg;
    setup_next   = setup_reg;
    addr_next    = addr_reg;
    irq_en_next  = irq_en_reg;
    done_next    = done_reg;
    prdata_next  = zero32;
    pready_next  = access;
    pslverr_next = 1'b0;
    gap_next     = (gap_reg != zero5) ? gap_reg - 5'h1 : zero5;
    if (access)
    begin
      case (paddr)
        port_test_control_off:
        begin
          prdata_next = ctrl_reg;
          // Writes inside the settling gap are dropped, not errored
          if (pwrite && gap_reg == zero5)
          begin
            ctrl_next = pwdata & ctrl_wmask;
            gap_next  = wait_cycles_c;
          end
        end
        test_dma_setup_off:
        begin
          prdata_next = setup_reg;
          if (pwrite)
            setup_next = pwdata & setup_wmask;
        end
        test_dma_memory_address_off:
        begin
          prdata_next = addr_reg;
          if (pwrite)
            addr_next = pwdata;
        end
        test_dma_status_off:
        begin
          prdata_next = zero32;
          prdata_next[done_flag_bit]   = done_reg;
          prdata_next[done_irq_en_bit] = irq_en_reg;
          prdata_next[busy_bit]        = dma_busy;
          if (pwrite)
          begin
            irq_en_next = pwdata[done_irq_en_bit];
            if (pwdata[done_flag_bit])
              done_next = 1'b0;
          end
        end
        default:
          pslverr_next = 1'b1;
      endcase
    end
    if (!dma_busy && !start_pulse)
      setup_next[dma_start_bit] = 1'b0;
    if (dma_done)
      done_next = 1'b1;
    irq_next = done_next && irq_en_next;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg    <= zero32;
      setup_reg   <= zero32;
      addr_reg    <= zero32;
      done_reg    <= 1'b0;
      irq_en_reg  <= 1'b0;
      irq_reg     <= 1'b0;
      prdata_reg  <= zero32;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      gap_reg     <= zero5;
    end
    else if (ce)
    begin
      ctrl_reg    <= ctrl_next;
      setup_reg   <= setup_next;
      addr_reg    <= addr_next;
      done_reg    <= done_next;
      irq_en_reg  <= irq_en_next;
      irq_reg     <= irq_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
      gap_reg     <= gap_next;
    end
  end

  test_dma_engine u_dma (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .start      (start_pulse),
    .to_fifo    (pwdata[dma_dir_bit]),
    .len        (pwdata[len_msb:len_lsb]),
    .base       (addr_reg),
    .mem_rdata  (mem_rdata),
    .fifo_ready (fifo_ready),
    .fifo_in    (rx_byte),
    .mem_reg    (mem_q),
    .fifo_out   (fifo_byte),
    .busy_reg   (dma_busy),
    .done_pulse (dma_done)
  );

  port_line_driver u_line (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .ctrl       (ctrl_reg),
    .fifo_byte  (fifo_byte),
    .fifo_ready (fifo_ready),
    .line_reg   (line_q),
    .tx_reg     (tx_q)
  );

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign irq        = irq_reg;
  assign mem_req    = mem_q;
  assign line_state = line_q;
  assign tx_byte    = tx_q;

  property p_ctrl_mask;
    @(posedge pclk) disable iff (!presetn)
      (ctrl_reg & ~ctrl_wmask) == zero32;
  endproperty
  a_ctrl_mask: assert property (p_ctrl_mask) else $error("reserved control bit set");

  property p_gap;
    @(posedge pclk) disable iff (!presetn)
      (ce && wr && hit(paddr, port_test_control_off) && gap_reg != zero5)
      |=> $stable(ctrl_reg);
  endproperty
  a_gap: assert property (p_gap) else $error("control written inside gap");

  property p_loop;
    @(posedge pclk) disable iff (!presetn)
      (ce && ctrl_reg[loopback_bit]) |=> line_state == line_loop;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback not entered");

  property p_k;
    @(posedge pclk) disable iff (!presetn)
      (ce && ctrl_reg[force_k_bit] && !ctrl_reg[loopback_bit]) |=> line_state == line_k;
  endproperty
  a_k: assert property (p_k) else $error("K not driven");

  property p_j;
    @(posedge pclk) disable iff (!presetn)
      (ce && ctrl_next == 32'h1 && ctrl_reg == 32'h1) |=> line_state == line_j;
  endproperty
  a_j: assert property (p_j) else $error("J not driven");

  property p_inert;
    @(posedge pclk) disable iff (!presetn)
      (ce && !dma_busy && !ctrl_reg[packet_pattern_bit]) |=> !dma_busy;
  endproperty
  a_inert: assert property (p_inert) else $error("DMA ran outside packet mode");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      (ce && start_pulse && pwdata[len_msb:len_lsb] != '0 && !dma_busy) |=> dma_busy;
  endproperty
  a_start: assert property (p_start) else $error("DMA did not start");

  property p_done;
    @(posedge pclk) disable iff (!presetn)
      (ce && dma_done) |=> done_reg;
  endproperty
  a_done: assert property (p_done) else $error("done flag not set");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      irq == (done_reg && irq_en_reg);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enabled flag");

  property p_tx;
    @(posedge pclk) disable iff (!presetn)
      tx_byte.valid |-> $past(ctrl_reg[packet_pattern_bit]);
  endproperty
  a_tx: assert property (p_tx) else $error("packet byte outside packet mode");

  // Bus answer: one wait state, pready stands for a single cycle
  sequence s_take;
    ce && access;
  endsequence

  sequence s_answer;
    pready ##1 !pready;
  endsequence

  property p_answer;
    @(posedge pclk) disable iff (!presetn || !ce)
      s_take |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer not a one-cycle pulse");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
      (ce && access && !hit(paddr, port_test_control_off) && !hit(paddr, test_dma_setup_off)
       && !hit(paddr, test_dma_memory_address_off) && !hit(paddr, test_dma_status_off))
      |=> pslverr && prdata == zero32;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

  property p_idle_rdata;
    @(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == zero32;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside answer");

  // Accepted control write loads both the value and the settling gap
  property p_ctrl_load;
    @(posedge pclk) disable iff (!presetn)
      (ce && wr && hit(paddr, port_test_control_off) && gap_reg == zero5)
      |=> gap_reg == wait_cycles_c && ctrl_reg == ($past(pwdata) & ctrl_wmask);
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) else $error("control write not taken");

  property p_gap_count;
    @(posedge pclk) disable iff (!presetn)
      (ce && gap_reg != zero5) |=> gap_reg == $past(gap_reg) - 5'h1;
  endproperty
  a_gap_count: assert property (p_gap_count) else $error("gap count skipped");

  property p_busy_read;
    @(posedge pclk) disable iff (!presetn)
      (ce && access && !pwrite && hit(paddr, test_dma_status_off))
      |=> prdata[busy_bit] == $past(dma_busy);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit misread");

  // Start bit reads back as one only while a transfer is under way
  property p_start_clear;
    @(posedge pclk) disable iff (!presetn)
      (ce && !dma_busy && !start_pulse) |=> !setup_reg[dma_start_bit];
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit stuck");
endmodule
`default_nettype wire

// ### tb/usb_test_device_model.sv
// Far-side model: local packet memory plus the test device on the port
`default_nettype none
module usb_test_device_model
  import port_test_pkg::*;
(
  input  wire logic       pclk,
  input  wire mem_req_t   mem_req,
  input  wire byte_beat_t tx_byte,
  output logic [7:0]      mem_rdata,
  output byte_beat_t      rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [1024];
  logic [7:0] tx_log [1024];
  int         tx_cnt;
  int         req_cnt;

  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = 8'(i) ^ 8'h5a;
    tx_cnt = 0;
    req_cnt = 0;
    mem_rdata = 8'h00;
    rx_byte = '0;
  end

  // Idle read lines toggle so a stale byte is never taken for data
  always @(posedge pclk)
  begin
    if (mem_req.req)
    begin
      req_cnt <= req_cnt + 1;
      if (mem_req.we)
        mem[mem_req.addr[9:0]] <= mem_req.data;
      mem_rdata <= mem_req.we ? ~mem_rdata : mem[mem_req.addr[9:0]];
    end
    else
      mem_rdata <= ~mem_rdata;
    // Test device stays attached and logs every byte sent to it
    if (tx_byte.valid)
    begin
      tx_log[tx_cnt[9:0]] <= tx_byte.data;
      tx_cnt <= tx_cnt + 1;
    end
  end

  task automatic send_rx(input logic [7:0] d);
    @(posedge pclk);
    rx_byte <= '{data: d, valid: 1'b1};
    @(posedge pclk);
    rx_byte <= '{data: ~d, valid: 1'b0};
  endtask
endmodule
`default_nettype wire

// ### tb/tb_port_test_mode_control.sv
// Testbench: register access, line forcing and test-packet DMA
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb_port_test_mode_control
  import port_test_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0]  paddr, mem_rdata;
  logic [31:0] pwdata, prdata, rd;
  byte_beat_t  rx_byte, tx_byte;
  mem_req_t    mem_req;
  line_state_t line_state;
  int          error_cnt, checks;

  port_test_mode_control u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_rdata(mem_rdata), .rx_byte(rx_byte),
    .mem_req(mem_req), .line_state(line_state), .tx_byte(tx_byte), .irq(irq));
  usb_test_device_model u_dev (.pclk(pclk), .mem_req(mem_req), .tx_byte(tx_byte),
    .mem_rdata(mem_rdata), .rx_byte(rx_byte));

  always #4 pclk = ~pclk;

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    `CHK("read", e, rd)
  endtask
  // Control writes keep the minimum spacing before the next one
  task automatic cwr(input logic [31:0] d);
    wr(port_test_control_off, d);
    repeat (wait_cycles + 2) @(posedge pclk);
  endtask

  task automatic t_reset;
    rchk(port_test_control_off, zero32);
    rchk(test_dma_setup_off, zero32);
    rchk(test_dma_memory_address_off, zero32);
    `CHK("line", line_idle, line_state)
    apb(8'h60, 1'b0, 32'h0);
    `CHK("slverr", 1'b1, er)
    $display("reset test done");
  endtask

  task automatic t_lines;
    cwr(32'h0000_0001);
    `CHK("line", line_j, line_state)
    cwr(32'h0000_0002);
    `CHK("line", line_k, line_state)
    cwr(32'h0000_0010);
    `CHK("line", line_loop, line_state)
    rchk(port_test_control_off, 32'h0000_0010);
    cwr(32'hffff_ffe8);
    rchk(port_test_control_off, zero32);
    // Second write too soon after the first is dropped
    wr(port_test_control_off, 32'h0000_0001);
    wr(port_test_control_off, 32'h0000_0002);
    repeat (wait_cycles + 2) @(posedge pclk);
    `CHK("line", line_j, line_state)
    cwr(zero32);
    `CHK("line", line_idle, line_state)
    $display("line test done");
  endtask

  task automatic t_idle_dma;
    wr(test_dma_setup_off, 32'hfe00_04ff);
    repeat (30) @(posedge pclk);
    `CHK("req", 0, u_dev.req_cnt)
    `CHK("tx", 0, u_dev.tx_cnt)
    rchk(test_dma_setup_off, 32'h0000_0402);
    $display("idle dma test done");
  endtask

  task automatic t_pkt;
    int n;
    cwr(32'h0000_0004);
    wr(test_dma_memory_address_off, 32'h0000_0100);
    wr(test_dma_setup_off, 32'h0003_ff03);
    n = 0;
    while (u_dev.tx_cnt < 1023 && n < 8000) begin @(posedge pclk); n++; end
    repeat (5) @(posedge pclk);
    `CHK("tx", 1023, u_dev.tx_cnt)
    `CHK("req", 1023, u_dev.req_cnt)
    for (int k = 0; k < 1023; k++)
      `CHK("byte", 8'(32'h100 + k) ^ 8'h5a, u_dev.tx_log[k])
    rchk(test_dma_status_off, 32'h0000_0001);
    `CHK("irq", 1'b0, irq)
    wr(test_dma_status_off, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    wr(test_dma_status_off, 32'h0000_0003);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b0, irq)
    rchk(test_dma_status_off, 32'h0000_0002);
    $display("packet test done");
  endtask

  task automatic t_rx;
    wr(test_dma_memory_address_off, 32'h0000_0300);
    wr(test_dma_setup_off, 32'h0000_0301);
    for (int k = 0; k < 3; k++)
      u_dev.send_rx(8'hc0 + 8'(k));
    repeat (5) @(posedge pclk);
    for (int k = 0; k < 3; k++)
      `CHK("mem", 8'hc0 + 8'(k), u_dev.mem[10'h300 + k])
    rchk(test_dma_status_off, 32'h0000_0003);
    `CHK("irq", 1'b1, irq)
    // Zero length finishes at once
    wr(test_dma_status_off, 32'h0000_0003);
    rchk(test_dma_status_off, 32'h0000_0002);
    wr(test_dma_setup_off, 32'h0000_0001);
    rchk(test_dma_status_off, 32'h0000_0003);
    $display("receive test done");
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0; presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; error_cnt = 0; checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_lines();
    t_idle_dma();
    t_pkt();
    t_rx();
    complete_run();
  end

  // Longest test is the 1023-byte packet; this leaves wide margin
  initial
  begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
